// >>> dblc_pkg.sv
/*
 package for the debug break/loop counter block: register map, fields,
 command codes and carrier structs.
 assumes a single hclk domain and an ahb-lite register bus.
*/
package dblc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_CNTR = 8'h08;
   localparam logic [7:0] ADDR_CMD = 8'h0c;
   // control register fields
   localparam int CTRL_HALT = 0;
   localparam int CTRL_BRKEN = 1;
   localparam int CTRL_LOOP = 2;
   localparam int CTRL_CMODE_LO = 3;
   localparam int CTRL_CMODE_HI = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // status register fields
   localparam int STAT_HALT = 0;
   localparam int STAT_IDLE = 1;
   localparam int STAT_CMDERR = 2;
   localparam int STAT_CNTSTOP = 3;
   // counter
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   // break opcode
   localparam logic [7:0] OPC_BREAK = 8'h00;
   // commands allowed while looping
   localparam logic [7:0] CMD_READ_STATUS = 8'h02;
   localparam logic [7:0] CMD_WRITE_CTRL = 8'h04;

   typedef enum logic [1:0] {
      CM_OFF,
      CM_CYCLES,
      CM_DOWN,
      CM_MATCH
   } dblc_cmode_e;

   typedef struct packed {
      logic fetch;
      logic [7:0] opcode;
      logic [15:0] pc;
      logic in_isr;
      logic ret_to_loop;
   } dblc_core_s;

   typedef struct packed {
      logic halt;
      logic loop;
      logic svc_en;
   } dblc_ctl_s;
endpackage

// >>> dblc_brk_decode.sv
/*
 break instruction decoder.
 assumes opcode and fetch are valid in the same cycle.
*/
`timescale 1ns/10ps
module dblc_brk_decode (
   input wire logic fetch,
   input wire logic [7:0] opcode,
   output logic is_break
);
   // erased-then-programmed flash byte doubles as breakpoint
   assign is_break = fetch && (opcode == dblc_pkg::OPC_BREAK);
endmodule // dblc_brk_decode

// >>> dblc_counter.sv
/*
 16-bit multipurpose debug counter.
 assumes enables come from the debugger fsm on hclk.
*/
`timescale 1ns/10ps
module dblc_counter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [1:0] cmode,
   input wire logic halted,
   input wire logic leave_debug,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic [15:0] pc,
   input wire logic fetch,
   output logic [15:0] count,
   output logic brk_req,
   output logic stopped
);
   logic [15:0] cnt_q;
   logic down_hit;
   logic match_hit;

   assign count = cnt_q;
   assign stopped = (cmode == dblc_pkg::CM_CYCLES) &&
                    (halted || cnt_q == dblc_pkg::CNT_MAX);
   assign down_hit = (cmode == dblc_pkg::CM_DOWN) && !halted &&
                     (cnt_q == dblc_pkg::CNT_ONE);
   assign match_hit = (cmode == dblc_pkg::CM_MATCH) && !halted && fetch &&
                      (cnt_q == pc);
   assign brk_req = down_hit || match_hit;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= dblc_pkg::CNT_ZERO;
      end else if (load) begin
         cnt_q <= load_val;
      end else if (leave_debug && cmode == dblc_pkg::CM_CYCLES) begin
         cnt_q <= dblc_pkg::CNT_ZERO;
      end else if (cmode == dblc_pkg::CM_CYCLES && !stopped) begin
         cnt_q <= cnt_q + dblc_pkg::CNT_ONE;
      end else if (cmode == dblc_pkg::CM_DOWN && !halted &&
                   cnt_q != dblc_pkg::CNT_ZERO) begin
         cnt_q <= cnt_q - dblc_pkg::CNT_ONE;
      end
   end

   a_cycle_step: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmode == dblc_pkg::CM_CYCLES && !stopped && !load && !leave_debug)
      |=> cnt_q == $past(cnt_q) + dblc_pkg::CNT_ONE)
      else $error("cycle counter did not step by one");
   a_cycle_sat: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmode == dblc_pkg::CM_CYCLES && cnt_q == dblc_pkg::CNT_MAX &&
       !load && !leave_debug) |=> cnt_q == dblc_pkg::CNT_MAX)
      else $error("cycle counter wrapped");
   a_clear_leave: assert property (@(posedge hclk) disable iff (!hresetn)
      (leave_debug && !load && cmode == dblc_pkg::CM_CYCLES)
      |=> cnt_q == dblc_pkg::CNT_ZERO)
      else $error("counter not cleared on leaving debug");
endmodule // dblc_counter

// >>> dblc_debug_break_loop.sv
/*
 debugger break handling: halt or loop on break instruction, idle status,
 command gating and the multipurpose counter, over an ahb-lite slave.
 assumes core status signals are synchronous to hclk and that the core
 obeys halt, loop and svc_en within the cycle they are given.
*/
// Summary of operation
// - with breaks enabled a break either halts the core or loops it.
// - while looping the core still serves dma and interrupt requests.
// - a break met inside a service routine while looping halts the core.
// - a status idle bit shows that the core loops on a break.
// - after loop clear the core returns to the break and halts itself.
// - most debugger commands are refused while looping, not halted.
// - the break instruction is opcode 00h.
// - a 16-bit counter can count clock cycles between breaks.
// - in countdown use the counter breaks on reaching zero.
// - in compare use the counter breaks on matching the pc.
// - cycle counting runs outside debug and stops at ffffh or on halt.
// - cycle counting clears to 0000h on leaving debug mode.
`timescale 1ns/10ps
module dblc_debug_break_loop (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire dblc_pkg::dblc_core_s core_in,
   output dblc_pkg::dblc_ctl_s core_ctl,
   output logic cmd_ok,
   output logic cmd_err
);
   typedef enum logic [1:0] {
      ST_RUN,
      ST_LOOP,
      ST_DRAIN,
      ST_HALT
   } dblc_state_e;

   dblc_state_e st_q;
   dblc_state_e st_d;
   logic [4:0] ctrl_q;
   logic [31:0] hrdata_q;
   logic cmd_ok_q;
   logic cmd_err_q;
   logic cmderr_sticky_q;
   logic halt_set_q;
   dblc_pkg::dblc_ctl_s ctl_q;
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] addr_q;
   logic is_break;
   logic cnt_brk;
   logic [15:0] count;
   logic cnt_stop;
   logic leave_debug;
   logic cnt_load;
   logic halted;
   logic [1:0] cmode;
   logic allowed_cmd;
   logic wr_ctrl;
   logic wr_cmd;

   assign halted = (st_q == ST_HALT);
   assign cmode = ctrl_q[dblc_pkg::CTRL_CMODE_HI:dblc_pkg::CTRL_CMODE_LO];

   dblc_brk_decode u_dec (
      .fetch(core_in.fetch),
      .opcode(core_in.opcode),
      .is_break(is_break)
   );

   // ahb-lite address phase capture; zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         wr_pend_q <= hsel && htrans[1] && hwrite;
         rd_pend_q <= hsel && htrans[1] && !hwrite;
         addr_q <= haddr;
      end
   end

   assign wr_ctrl = wr_pend_q && addr_q == dblc_pkg::ADDR_CTRL;
   assign wr_cmd = wr_pend_q && addr_q == dblc_pkg::ADDR_CMD;
   assign cnt_load = wr_pend_q && addr_q == dblc_pkg::ADDR_CNTR;
   assign leave_debug = halted && st_d != ST_HALT;

   dblc_counter u_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .cmode(cmode),
      .halted(halted),
      .leave_debug(leave_debug),
      .load(cnt_load),
      .load_val(hwdata[15:0]),
      .pc(core_in.pc),
      .fetch(core_in.fetch),
      .count(count),
      .brk_req(cnt_brk),
      .stopped(cnt_stop)
   );

   // break state machine
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_RUN: begin
            if (cnt_brk) begin
               st_d = ST_HALT;
            end else if (is_break && ctrl_q[dblc_pkg::CTRL_BRKEN]) begin
               if (ctrl_q[dblc_pkg::CTRL_LOOP]) begin
                  st_d = ST_LOOP;
               end else begin
                  st_d = ST_HALT;
               end
            end else if (wr_ctrl && hwdata[dblc_pkg::CTRL_HALT]) begin
               st_d = ST_HALT;
            end
         end
         ST_LOOP: begin
            if (is_break && core_in.in_isr) begin
               st_d = ST_HALT;
            end else if (!ctrl_q[dblc_pkg::CTRL_LOOP]) begin
               st_d = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // isr may still be running; wait for return to the break
            if (core_in.ret_to_loop || (is_break && !core_in.in_isr)) begin
               st_d = ST_HALT;
            end else if (is_break && core_in.in_isr) begin
               st_d = ST_HALT;
            end
         end
         ST_HALT: begin
            if (!ctrl_q[dblc_pkg::CTRL_HALT] && !halt_set_q) begin
               st_d = ST_RUN;
            end
         end
         default: st_d = ST_RUN;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= ST_RUN;
      end else begin
         st_q <= st_d;
      end
   end

   // control register; hardware sets the halt bit on entering debug
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= dblc_pkg::CTRL_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= hwdata[4:0];
         end
         if (st_d == ST_HALT && st_q != ST_HALT) begin
            ctrl_q[dblc_pkg::CTRL_HALT] <= 1'b1;
         end
      end
   end

   // one-cycle guard so a halt set this cycle is not left at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halt_set_q <= 1'b0;
      end else begin
         halt_set_q <= (st_d == ST_HALT && st_q != ST_HALT);
      end
   end

   // core controls; loop keeps interrupt and dma service open
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_q <= '0;
      end else begin
         ctl_q.halt <= (st_d == ST_HALT);
         ctl_q.loop <= (st_d == ST_LOOP) || (st_d == ST_DRAIN);
         ctl_q.svc_en <= (st_d != ST_HALT);
      end
   end
   assign core_ctl = ctl_q;

   // command gate: only status and control access while not halted
   assign allowed_cmd = hwdata[7:0] == dblc_pkg::CMD_READ_STATUS ||
                        hwdata[7:0] == dblc_pkg::CMD_WRITE_CTRL;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_ok_q <= 1'b0;
         cmd_err_q <= 1'b0;
      end else begin
         cmd_ok_q <= wr_cmd && (halted || allowed_cmd);
         cmd_err_q <= wr_cmd && !halted && !allowed_cmd;
      end
   end
   assign cmd_ok = cmd_ok_q;
   assign cmd_err = cmd_err_q;

   // sticky command error; a new refusal wins over a clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmderr_sticky_q <= 1'b0;
      end else if (wr_cmd && !halted && !allowed_cmd) begin
         cmderr_sticky_q <= 1'b1;
      end else if (wr_pend_q && addr_q == dblc_pkg::ADDR_STAT &&
                   hwdata[dblc_pkg::STAT_CMDERR]) begin
         cmderr_sticky_q <= 1'b0;
      end
   end

   // read data registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr)
            dblc_pkg::ADDR_CTRL: hrdata_q <= {27'h0, ctrl_q};
            dblc_pkg::ADDR_STAT: hrdata_q <= {28'h0, cnt_stop,
               cmderr_sticky_q, st_q == ST_LOOP || st_q == ST_DRAIN,
               halted};
            dblc_pkg::ADDR_CNTR: hrdata_q <= {16'h0, count};
            default: hrdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   a_loop_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == ST_LOOP) |-> ctl_q.loop && ctl_q.svc_en)
      else $error("looping core lost service enable");
   a_break_halt: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == ST_RUN && is_break && ctrl_q[dblc_pkg::CTRL_BRKEN] &&
       !ctrl_q[dblc_pkg::CTRL_LOOP]) |=> halted)
      else $error("break did not halt");
   a_isr_break: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_q == ST_LOOP && is_break && core_in.in_isr) |=> halted)
      else $error("break in service routine did not halt");
   sequence s_loop_clear;
      st_q == ST_LOOP && !ctrl_q[dblc_pkg::CTRL_LOOP] && !is_break;
   endsequence
   sequence s_return;
      st_q == ST_DRAIN && core_in.ret_to_loop;
   endsequence
   a_drain_halt: assert property (@(posedge hclk) disable iff (!hresetn)
      s_loop_clear ##1 s_return |=> halted &&
      ctrl_q[dblc_pkg::CTRL_HALT])
      else $error("return to break did not enter debug");
   a_cmd_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_cmd && st_q == ST_LOOP && !allowed_cmd) |=> cmd_err_q &&
      !cmd_ok_q)
      else $error("command accepted while looping");
endmodule // dblc_debug_break_loop

// >>> dblc_core_model.sv
/*
 core model: fetches, a service routine and return to a looped break.
 assumes core_ctl is obeyed from the next clock edge.
*/
`timescale 1ns/10ps
module dblc_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire dblc_pkg::dblc_ctl_s ctl,
   input wire logic isr_req,
   input wire logic isr_brk,
   input wire logic [15:0] brk_pc,
   output dblc_pkg::dblc_core_s core
);
   logic [1:0] div_q;
   logic parked_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core <= '0;
         div_q <= 2'h0;
         parked_q <= 1'b0;
      end else begin
         div_q <= div_q + 2'h1;
         core.fetch <= 1'b0;
         core.ret_to_loop <= 1'b0;
         // idle opcode toggles so a stale fetch is never seen
         core.opcode <= ~core.opcode;
         if (ctl.halt) begin
            parked_q <= 1'b0;
         end else if (ctl.loop || parked_q) begin
            parked_q <= 1'b1;
            if (isr_req && ctl.svc_en) begin
               core.in_isr <= 1'b1;
               core.fetch <= (div_q == 2'h0);
               core.opcode <= isr_brk ? dblc_pkg::OPC_BREAK : 8'h0f;
            end else if (core.in_isr) begin
               // back at the looped break after the routine
               core.in_isr <= 1'b0;
               core.ret_to_loop <= 1'b1;
            end
         end else if (div_q == 2'h0) begin
            core.fetch <= 1'b1;
            core.pc <= core.pc + 16'h1;
            core.opcode <= (core.pc + 16'h1 == brk_pc) ?
               dblc_pkg::OPC_BREAK : 8'h0f;
         end
      end
   end
endmodule // dblc_core_model

// >>> testbench.sv
/*
 testbench for the debug break/loop block: ahb-lite register tasks and
 scenario sequences against a core model.
 assumes zero-wait slave and hclk at 100 mhz.
*/
`timescale 1ns/10ps
module testbench;
   logic hclk, hresetn, hsel, hwrite, hready, isr_req, isr_brk;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd, r1;
   logic hreadyout, hresp, cmd_ok, cmd_err;
   logic [15:0] brk_pc, p;
   dblc_pkg::dblc_core_s core_in;
   dblc_pkg::dblc_ctl_s core_ctl;
   int error_cnt, checked, cyc, t_a, t1, ok_n, err_n;
   assign hready = hreadyout;
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      ok_n <= ok_n + int'(cmd_ok);
      err_n <= err_n + int'(cmd_err);
   end
   dblc_debug_break_loop DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .core_in(core_in),
      .core_ctl(core_ctl), .cmd_ok(cmd_ok), .cmd_err(cmd_err));
   dblc_core_model core (.hclk(hclk), .hresetn(hresetn), .ctl(core_ctl),
      .isr_req(isr_req), .isr_brk(isr_brk), .brk_pc(brk_pc),
      .core(core_in));
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task cmp_bit(input string nm, input logic e, input logic g);
      cmp_word(nm, {31'h0, e}, {31'h0, g});
   endtask
   task bail(input string nm);
      cmp_bit(nm, 1'b1, 1'b0);
      tally_and_finish;
   endtask
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) bail("hready");
   endtask
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'b010;
      wait_rdy;
      t_a = cyc;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask
   task rdreg(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask
   task cmd(input logic [7:0] c);
      xfer(1'b1, dblc_pkg::ADDR_CMD, {24'h0, c});
      // pulse lands one cycle after the data phase
      repeat (2) @(posedge hclk);
   endtask
   task wait_ctl(input logic lp, input int lim);
      int n;
      n = 0;
      while ((lp ? core_ctl.loop : core_ctl.halt) !== 1'b1) begin
         if (n >= lim) bail("ctl wait");
         n++;
         @(posedge hclk);
      end
   endtask
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00;
      hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; isr_req = 1'b0;
      isr_brk = 1'b0; brk_pc = 16'h0020; error_cnt = 0; checked = 0;
      cyc = 0; ok_n = 0; err_n = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rdreg(dblc_pkg::ADDR_CTRL); cmp_word("ctrl", 32'h0, rd);
      rdreg(dblc_pkg::ADDR_CNTR); cmp_word("cntr", 32'h0, rd);
      xfer(1'b1, 8'h10, 32'hffffffff);
      rdreg(8'h10); cmp_word("unmapped", 32'h0, rd);
      $display("test reset done");
      xfer(1'b1, dblc_pkg::ADDR_CTRL, 32'h0a);
      wait_ctl(1'b0, 400);
      cmp_word("halt pc", 32'h20, {16'h0, core_in.pc});
      rdreg(dblc_pkg::ADDR_STAT); cmp_word("stat", 32'h1, rd & 32'h3);
      cmd(8'h10); cmp_word("cmd ok", 32'h1, ok_n);
      $display("test halt done");
      brk_pc <= 16'hffff;
      xfer(1'b1, dblc_pkg::ADDR_CTRL, 32'h0a);
      rdreg(dblc_pkg::ADDR_CNTR); r1 = rd; t1 = t_a;
      cmp_bit("cntr clear", 1'b1, rd < 32'h10);
      repeat (9) @(posedge hclk);
      rdreg(dblc_pkg::ADDR_CNTR);
      cmp_word("cntr step", 32'(t_a - t1), rd - r1);
      cmd(8'h10); cmp_word("cmd err", 32'h1, err_n);
      cmd(dblc_pkg::CMD_READ_STATUS); cmp_word("cmd ok", 32'h2, ok_n);
      rdreg(dblc_pkg::ADDR_STAT); cmp_word("err flag", 32'h4, rd & 32'h4);
      brk_pc <= core_in.pc + 16'h2;
      wait_ctl(1'b0, 40);
      rdreg(dblc_pkg::ADDR_CNTR); r1 = rd;
      repeat (5) @(posedge hclk);
      rdreg(dblc_pkg::ADDR_CNTR); cmp_word("cntr held", r1, rd);
      brk_pc <= 16'hffff;
      xfer(1'b1, dblc_pkg::ADDR_CTRL, 32'h0a);
      xfer(1'b1, dblc_pkg::ADDR_CNTR, 32'hfff0);
      repeat (30) @(posedge hclk);
      rdreg(dblc_pkg::ADDR_CNTR); cmp_word("cntr sat", 32'hffff, rd);
      rdreg(dblc_pkg::ADDR_STAT); cmp_word("stopped", 32'h8, rd & 32'h8);
      $display("test counter done");
      xfer(1'b1, dblc_pkg::ADDR_CTRL, 32'h12);
      xfer(1'b1, dblc_pkg::ADDR_CNTR, 32'h14);
      repeat (10) @(posedge hclk);
      cmp_bit("early halt", 1'b0, core_ctl.halt);
      wait_ctl(1'b0, 40);
      rdreg(dblc_pkg::ADDR_CNTR); cmp_word("down zero", 32'h0, rd);
      $display("test countdown done");
      xfer(1'b1, dblc_pkg::ADDR_CTRL, 32'h1a);
      p = core_in.pc + 16'h6;
      xfer(1'b1, dblc_pkg::ADDR_CNTR, {16'h0, p});
      wait_ctl(1'b0, 80);
      cmp_word("match pc", {16'h0, p}, {16'h0, core_in.pc});
      $display("test match done");
      brk_pc <= core_in.pc + 16'h4;
      xfer(1'b1, dblc_pkg::ADDR_CTRL, 32'h06);
      wait_ctl(1'b1, 60);
      cmp_bit("loop halt", 1'b0, core_ctl.halt);
      cmp_bit("svc", 1'b1, core_ctl.svc_en);
      rdreg(dblc_pkg::ADDR_STAT); cmp_word("idle", 32'h2, rd & 32'h3);
      cmd(8'h10); cmp_word("cmd err", 32'h2, err_n);
      // interrupts only when a scenario asks
      isr_req <= 1'b1;
      repeat (6) @(posedge hclk);
      cmp_bit("in isr", 1'b1, core_in.in_isr);
      xfer(1'b1, dblc_pkg::ADDR_CTRL, 32'h02);
      repeat (8) @(posedge hclk);
      cmp_bit("isr halt", 1'b0, core_ctl.halt);
      isr_req <= 1'b0;
      wait_ctl(1'b0, 20);
      rdreg(dblc_pkg::ADDR_STAT); cmp_word("self halt", 32'h1, rd & 32'h3);
      $display("test loop done");
      brk_pc <= core_in.pc + 16'h4;
      xfer(1'b1, dblc_pkg::ADDR_CTRL, 32'h06);
      wait_ctl(1'b1, 60);
      isr_brk <= 1'b1;
      isr_req <= 1'b1;
      wait_ctl(1'b0, 30);
      cmp_bit("isr stop", 1'b1, core_in.in_isr);
      $display("test isr break done");
      tally_and_finish;
   end
endmodule // testbench
